// >>> rtl/pb_csr_bank.sv
// Purpose: Configuration, control and status registers of the peripheral bridge.
// Assumes: Backplane event inputs are one-cycle pulses on mclk_i.
// Notes: Register port answers every access one cycle after reg_sel_i.
`timescale 1ns/1ps
module pb_csr_bank import pb_pkg::*; #(
  parameter int BRIDGE_INIT_CTL_CYC = BRIDGE_INIT_CTL_US * CLK_MHZ,
  parameter int PF_STEP_CYC = PF_MS * 1000 * CLK_MHZ / PF_PHASES,
  parameter logic [5:0] TYPE_CODE = 6'h11 // arbitrary value
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic reg_sel_i,
  input wire logic reg_we_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_ack_o,
  input wire logic bp_parity_err_i,
  input wire logic bp_wmask_cmd_i,
  input wire logic bp_wdata_i,
  input wire logic bp_read_cmd_i,
  input wire logic bp_rdata_i,
  input wire logic bp_ilk_rmask_i,
  input wire logic bp_ilk_wmask_periph_i,
  input wire logic bp_transmitting_i,
  input wire logic [3:0] bp_id_driven_i,
  input wire logic [3:0] bp_id_latched_i,
  input wire logic bp_fault_i,
  input wire logic backplane_a_i,
  input wire logic bus_dead_i,
  input wire logic ac_low_warning_i,
  input wire logic periph_init_in_i,
  input wire logic periph_ac_low_in_i,
  input wire logic periph_power_ok_i,
  input wire logic [1:0] jumper_i,
  input wire logic interrupt_fielding_switch_i,
  input wire logic periph_br_i,
  input wire logic dma_read_sent_i,
  input wire logic dma_read_data_i,
  input wire logic dev_timeout_i,
  input wire logic [5:0] dma_err_i,
  input wire logic [8:0] dma_map_idx_i,
  input wire logic select_timeout_flag_i,
  input wire logic slave_sync_timeout_flag_i,
  input wire logic [3:0] vec_save_i,
  input wire logic [3:0] vec_read_ok_i,
  output logic dma_map_blocked_o,
  output logic [4:0] map_disable_field_o,
  output logic [8:0] failed_map_entry_reg_o,
  output logic dev_irq_o,
  output logic dma_irq_o,
  output logic pio_irq_o,
  output logic env_irq_o,
  output logic periph_ac_low_o,
  output logic periph_dc_low_o,
  output logic periph_init_o,
  output logic init_busy_o,
  output logic init_start_o
);
  localparam int TW = 24;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic [5:0] sync_lv;
  logic ac_low_s, pinit_s, paclo_s, pok_s;
  logic [1:0] jmp_s;
  logic ac_low_q, pinit_q, paclo_q;
  logic [5:0] flt;
  logic pdn, pup, pinit_seen, ppdn, pic;
  logic [4:0] map_disable_field;
  logic en_dev, en_dma, en_pio, en_env, pf_ctl;
  logic [3:0] vec_full;
  logic [6:0] err;
  logic leb, sto, ssto;
  logic wr_cfg, wr_ctl, wr_sts, init_pulse, pf_start;
  logic [31:0] cfg_clr, sts_clr;
  logic wseq_pend, rd_out, ilk_seen;
  logic [5:0] flt_set;
  logic [6:0] err_ev;
  logic locked, read_data_timeout_exp, pf_exp, pf_tmr_start, pf_done;
  pb_pf_t pf, next_pf;
  logic [31:0] cfg_word, ctl_word, sts_word;

  pb_pin_sync #(.W(6)) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .pin_i({ac_low_warning_i, periph_init_in_i, periph_ac_low_in_i, periph_power_ok_i,
      jumper_i}),
    .level_o(sync_lv)
  );
  assign {ac_low_s, pinit_s, paclo_s, pok_s, jmp_s} = sync_lv;

  assign wr_cfg = reg_sel_i && reg_we_i && hit(reg_addr_i, CFG_OFS);
  assign wr_ctl = reg_sel_i && reg_we_i && hit(reg_addr_i, CTL_OFS);
  assign wr_sts = reg_sel_i && reg_we_i && hit(reg_addr_i, STS_OFS);
  assign cfg_clr = wr_cfg ? reg_wdata_i : 32'h0000_0000;
  assign sts_clr = wr_sts ? reg_wdata_i : 32'h0000_0000;
  assign init_pulse = wr_ctl && reg_wdata_i[CTL_INIT] && !init_busy_o;
  assign pf_start = init_pulse || (wr_ctl && reg_wdata_i[CTL_PF] && !pf_ctl);

  // Timers: init 500 us, power-fail phases, DMA read data
  pb_timer #(.W(TW)) u_init_tmr (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .start_i(init_pulse),
    .cancel_i(1'b0),
    .load_i(TW'(BRIDGE_INIT_CTL_CYC)),
    .busy_o(init_busy_o),
    .expired_o()
  );
  pb_timer #(.W(TW)) u_pf_tmr (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .start_i(pf_tmr_start),
    .cancel_i(1'b0),
    .load_i(TW'(PF_STEP_CYC)),
    .busy_o(),
    .expired_o(pf_exp)
  );
  pb_timer #(.W(TW)) u_read_data_timeout_tmr (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .start_i(dma_read_sent_i),
    .cancel_i(dma_read_data_i || dev_timeout_i),
    .load_i(TW'(READ_DATA_TIMEOUT_CYC)),
    .busy_o(),
    .expired_o(read_data_timeout_exp)
  );

  // Backplane protocol trackers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wseq_pend <= 1'b0;
      rd_out <= 1'b0;
      ilk_seen <= 1'b0;
    end else begin
      wseq_pend <= bp_wmask_cmd_i;
      if (bp_read_cmd_i) begin
        rd_out <= 1'b1;
      end else if (bp_rdata_i) begin
        rd_out <= 1'b0;
      end
      if (bp_ilk_rmask_i) begin
        ilk_seen <= 1'b1;
      end else if (bp_ilk_wmask_periph_i) begin
        ilk_seen <= 1'b0;
      end
    end
  end

  always_comb begin
    flt_set = '0;
    flt_set[F_PAR] = bp_parity_err_i;
    flt_set[F_WSQ] = wseq_pend && !bp_wdata_i;
    flt_set[F_URD] = bp_rdata_i && !rd_out;
    flt_set[F_ISQ] = bp_ilk_wmask_periph_i && !ilk_seen;
    flt_set[F_MXT] = bp_transmitting_i && (bp_id_driven_i != bp_id_latched_i);
    flt_set[F_XMT] = bp_transmitting_i && bp_fault_i;
  end

  // Configuration flags; a set in the clear cycle wins
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      flt <= '0;
      ac_low_q <= 1'b0;
      pinit_q <= 1'b0;
      paclo_q <= 1'b0;
      pdn <= 1'b0;
      pup <= 1'b0;
      pinit_seen <= 1'b0;
      ppdn <= 1'b0;
      pic <= 1'b0;
    end else begin
      ac_low_q <= ac_low_s;
      pinit_q <= pinit_s;
      paclo_q <= paclo_s;
      flt <= flt_set | (flt & ~cfg_clr[CFG_FLT_LSB +: 6]);
      pdn <= (ac_low_s && !ac_low_q) ||
        (pdn && !cfg_clr[CFG_PDN] && !(!ac_low_s && ac_low_q));
      pup <= (!ac_low_s && ac_low_q) ||
        (pup && !cfg_clr[CFG_PUP] && !(ac_low_s && !ac_low_q));
      pinit_seen <= (pinit_s && !pinit_q) || (pinit_seen && !cfg_clr[CFG_PINIT] && !pf_done);
      ppdn <= (paclo_s && !paclo_q) || (ppdn && !cfg_clr[CFG_PPDN] && !pf_done);
      pic <= pf_done || (pic && !cfg_clr[CFG_PIC] && !(pinit_s && !pinit_q));
    end
  end

  // Control register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      map_disable_field <= '0;
      en_dev <= CTL_RESET[CTL_DEV_EN];
      en_dma <= CTL_RESET[CTL_DMA_EN];
      en_pio <= CTL_RESET[CTL_PIO_EN];
      en_env <= CTL_RESET[CTL_ENV_EN];
      pf_ctl <= CTL_RESET[CTL_PF];
    end else if (init_pulse) begin
      map_disable_field <= '0;
      en_dev <= 1'b0;
      en_dma <= 1'b0;
      en_pio <= 1'b0;
      en_env <= 1'b0;
      pf_ctl <= 1'b0;
    end else begin
      if (wr_ctl) begin
        map_disable_field <= reg_wdata_i[CTL_MRD_LSB +: 5];
        en_dev <= reg_wdata_i[CTL_DEV_EN];
        en_dma <= reg_wdata_i[CTL_DMA_EN];
        en_pio <= reg_wdata_i[CTL_PIO_EN];
        en_env <= reg_wdata_i[CTL_ENV_EN];
        pf_ctl <= reg_wdata_i[CTL_PF];
      end
      if (backplane_a_i || bus_dead_i) begin
        en_dev <= 1'b0;
        en_pio <= 1'b0;
        en_env <= 1'b0;
      end
      if (backplane_a_i) begin
        en_dma <= 1'b0;
      end
    end
  end

  // Status register; the DMA error field locks on its first error
  assign err_ev = {read_data_timeout_exp, dma_err_i};
  assign locked = |err;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      err <= '0;
      leb <= 1'b0;
      sto <= 1'b0;
      ssto <= 1'b0;
      vec_full <= '0;
      failed_map_entry_reg_o <= '0;
    end else if (init_pulse) begin
      err <= '0;
      leb <= 1'b0;
      sto <= 1'b0;
      ssto <= 1'b0;
      vec_full <= '0;
    end else begin
      err[6:5] <= (locked ? 2'b00 : err_ev[6:5]) | (err[6:5] & ~sts_clr[STS_RDS +: 2]);
      err[4:0] <= (locked ? 5'b00000 : err_ev[4:0]) | (err[4:0] & ~sts_clr[STS_ERR_LSB +: 5]);
      if (!locked && |err_ev) begin
        failed_map_entry_reg_o <= dma_map_idx_i;
      end
      leb <= (locked && |err_ev) || (leb && !sts_clr[STS_LEB]);
      sto <= select_timeout_flag_i || (sto && !sts_clr[STS_STO]);
      ssto <= slave_sync_timeout_flag_i || (ssto && !sts_clr[STS_SSTO]);
      vec_full <= vec_save_i | (vec_full & ~vec_read_ok_i);
    end
  end

  // Peripheral bus power-fail sequencer
  always_comb begin
    next_pf = pf;
    pf_tmr_start = 1'b0;
    if (pf_start) begin
      next_pf = PF_AC_LOW_WARNING;
      pf_tmr_start = 1'b1;
    end else begin
      unique case (pf)
        PF_IDLE: next_pf = PF_IDLE;
        PF_AC_LOW_WARNING: if (pf_exp) begin
          next_pf = PF_DC_LOW_WARNING;
          pf_tmr_start = 1'b1;
        end
        PF_DC_LOW_WARNING: if (pf_exp) begin
          next_pf = PF_HOLD;
        end
        PF_HOLD: if (!pf_ctl && pok_s) begin
          next_pf = PF_UP_DC;
          pf_tmr_start = 1'b1;
        end
        PF_UP_DC: if (pf_exp) begin
          next_pf = PF_UP_INIT;
          pf_tmr_start = 1'b1;
        end
        PF_UP_INIT: if (pf_exp) begin
          next_pf = PF_UP_AC;
          pf_tmr_start = 1'b1;
        end
        PF_UP_AC: if (pf_exp) begin
          next_pf = PF_IDLE;
        end
        default: next_pf = PF_IDLE;
      endcase
    end
  end
  assign pf_done = (pf == PF_UP_AC) && pf_exp && !pf_start;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pf <= PF_IDLE;
      periph_ac_low_o <= 1'b0;
      periph_dc_low_o <= 1'b0;
      periph_init_o <= 1'b0;
    end else begin
      pf <= next_pf;
      periph_ac_low_o <= (next_pf != PF_IDLE) && (next_pf != PF_UP_AC);
      periph_dc_low_o <= (next_pf == PF_DC_LOW_WARNING) || (next_pf == PF_HOLD);
      periph_init_o <= (next_pf == PF_HOLD) || (next_pf == PF_UP_DC);
    end
  end

  // Register reads; control and status are hidden while init runs
  assign cfg_word = {flt, 2'b00, pdn, pup, 3'b000, pinit_seen, ppdn, pic, 8'h00,
    TYPE_CODE, jmp_s};
  assign ctl_word = {1'b0, map_disable_field, 20'h0_0000, en_dev, en_dma, en_pio, en_env, pf_ctl,
    init_busy_o};
  assign sts_word = {4'h0, vec_full, 13'h0000, err[6:5], 1'b0, err[4:0], leb, sto, ssto};

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_ack_o <= 1'b0;
      reg_rdata_o <= '0;
      init_start_o <= 1'b0;
      dma_map_blocked_o <= 1'b0;
      map_disable_field_o <= '0;
    end else begin
      reg_ack_o <= reg_sel_i;
      reg_rdata_o <= 32'h0000_0000;
      if (reg_sel_i && !reg_we_i) begin
        if (hit(reg_addr_i, CFG_OFS)) begin
          reg_rdata_o <= cfg_word;
        end else if (hit(reg_addr_i, CTL_OFS) && !init_busy_o) begin
          reg_rdata_o <= ctl_word;
        end else if (hit(reg_addr_i, STS_OFS) && !init_busy_o) begin
          reg_rdata_o <= sts_word;
        end
      end
      init_start_o <= init_pulse;
      dma_map_blocked_o <= {5'h00, dma_map_idx_i} < (14'(map_disable_field) * 14'(MAP_GROUP));
      map_disable_field_o <= map_disable_field;
    end
  end

  // Interrupt request levels
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dev_irq_o <= 1'b0;
      dma_irq_o <= 1'b0;
      pio_irq_o <= 1'b0;
      env_irq_o <= 1'b0;
    end else begin
      dev_irq_o <= en_dev && interrupt_fielding_switch_i && periph_br_i;
      dma_irq_o <= en_dma && locked;
      pio_irq_o <= en_pio && (sto || ssto);
      env_irq_o <= en_env && (pdn || pup || pinit_seen || ppdn || pic);
    end
  end

  a_par_flag: assert property (
    @(posedge mclk_i) disable iff (rst_i) bp_parity_err_i |=> flt[F_PAR])
    else $error("parity fault flag not set");
  a_wseq_flag: assert property (
    @(posedge mclk_i) disable iff (rst_i) bp_wmask_cmd_i ##1 !bp_wdata_i |=> flt[F_WSQ])
    else $error("write sequence fault missed");
  a_mxt_flag: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    bp_transmitting_i && (bp_id_driven_i != bp_id_latched_i) |=> flt[F_MXT])
    else $error("multiple transmitter fault missed");
  a_pdn_pup_excl: assert property (
    @(posedge mclk_i) disable iff (rst_i) !(pdn && pup))
    else $error("power down and power up flags both set");
  a_backplane_a_clear: assert property (
    @(posedge mclk_i) disable iff (rst_i) backplane_a_i && !init_pulse
    |=> !en_dma && !en_pio && !en_env && !en_dev)
    else $error("enables survive backplane backplane_a");
  a_init_busy_len: assert property (
    @(posedge mclk_i) disable iff (rst_i) $rose(init_busy_o) |-> init_busy_o [*8])
    else $error("bridge init ended too early");
  a_read_gate: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    reg_sel_i && !reg_we_i && init_busy_o && !hit(reg_addr_i, CFG_OFS)
    |=> reg_ack_o && reg_rdata_o == 32'h0000_0000)
    else $error("register readable during bridge init");
  a_failed_map_entry_reg_frozen: assert property (
    @(posedge mclk_i) disable iff (rst_i) locked |=> $stable(failed_map_entry_reg_o))
    else $error("failed map entry changed while locked");
  a_pf_order: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    $rose(periph_dc_low_o) |-> periph_ac_low_o && !periph_init_o)
    else $error("power-fail lines out of order");
  a_vec_clear: assert property (
    @(posedge mclk_i) disable iff (rst_i) vec_read_ok_i[0] && !vec_save_i[0] |=> !vec_full[0])
    else $error("vector full flag not cleared by read");
  a_dev_irq: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    dev_irq_o |-> $past(en_dev && interrupt_fielding_switch_i && periph_br_i))
    else $error("device interrupt passed without enable");
endmodule : pb_csr_bank

// >>> rtl/pb_pkg.sv
// Purpose: Shared constants and types of the peripheral bridge register bank.
// Assumes: 20 MHz adapter clock; registers are 32-bit words at byte offsets.
// Notes: Bit positions are indices into the register words; F_PAR to F_XMT index the six-bit fault field.
package pb_pkg;
  localparam int CLK_MHZ = 20;
  localparam logic [11:0] CFG_OFS = 12'h000;
  localparam logic [11:0] CTL_OFS = 12'h004;
  localparam logic [11:0] STS_OFS = 12'h008;
  // Configuration word
  localparam int CFG_FLT_LSB = 26;
  localparam int CFG_PDN = 23;
  localparam int CFG_PUP = 22;
  localparam int CFG_PINIT = 18;
  localparam int CFG_PPDN = 17;
  localparam int CFG_PIC = 16;
  localparam int F_PAR = 5;
  localparam int F_WSQ = 4;
  localparam int F_URD = 3;
  localparam int F_ISQ = 2;
  localparam int F_MXT = 1;
  localparam int F_XMT = 0;
  // Control word
  localparam int CTL_MRD_LSB = 26;
  localparam int CTL_DEV_EN = 5;
  localparam int CTL_DMA_EN = 4;
  localparam int CTL_PIO_EN = 3;
  localparam int CTL_ENV_EN = 2;
  localparam int CTL_PF = 1;
  localparam int CTL_INIT = 0;
  localparam logic [31:0] CTL_RESET = 32'h0000_0004;
  // Status word
  localparam int STS_VEC_LSB = 24;
  localparam int STS_READ_DATA_TIMEOUT = 10;
  localparam int STS_RDS = 9;
  localparam int STS_ERR_LSB = 3;
  localparam int STS_LEB = 2;
  localparam int STS_STO = 1;
  localparam int STS_SSTO = 0;
  localparam int MAP_GROUP = 16;
  // Timing
  localparam int READ_DATA_TIMEOUT_US = 100;
  localparam int READ_DATA_TIMEOUT_CYC = READ_DATA_TIMEOUT_US * CLK_MHZ;
  localparam int BRIDGE_INIT_CTL_US = 500;
  localparam int PF_MS = 25;
  localparam int PF_PHASES = 5;
  typedef enum logic [2:0] {
    PF_IDLE = 3'b000,
    PF_AC_LOW_WARNING = 3'b001,
    PF_DC_LOW_WARNING = 3'b010,
    PF_HOLD = 3'b011,
    PF_UP_DC = 3'b100,
    PF_UP_INIT = 3'b101,
    PF_UP_AC = 3'b110
  } pb_pf_t;
endpackage : pb_pkg

// >>> rtl/pb_pin_sync.sv
// Purpose: Three-stage synchroniser for pins from outside the clock domain.
// Assumes: Pins are slow levels.
// Notes: A bit changes only once stages two and three agree.
`timescale 1ns/1ps
module pb_pin_sync #(
  parameter int W = 1
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);
  logic [W-1:0] q1;
  logic [W-1:0] q2;
  logic [W-1:0] q3;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q1 <= '0;
      q2 <= '0;
      q3 <= '0;
      level_o <= '0;
    end else begin
      q1 <= pin_i;
      q2 <= q1;
      q3 <= q2;
      // Stage one feeds stage two only
      level_o <= (q2 & q3) | (level_o & (q2 ^ q3));
    end
  end
endmodule : pb_pin_sync

// >>> rtl/pb_timer.sv
// Purpose: Retriggerable one-shot down counter.
// Assumes: load_i is at least one.
// Notes: expired_o pulses for one cycle when the count runs out.
`timescale 1ns/1ps
module pb_timer #(
  parameter int W = 24
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic cancel_i,
  input wire logic [W-1:0] load_i,
  output logic busy_o,
  output logic expired_o
);
  logic [W-1:0] count;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= '0;
      busy_o <= 1'b0;
      expired_o <= 1'b0;
    end else begin
      expired_o <= 1'b0;
      if (start_i) begin
        count <= load_i;
        busy_o <= 1'b1;
      end else if (cancel_i) begin
        busy_o <= 1'b0;
      end else if (busy_o) begin
        count <= count - 1'b1;
        if (count == {{(W-1){1'b0}}, 1'b1}) begin
          busy_o <= 1'b0;
          expired_o <= 1'b1;
        end
      end
    end
  end
endmodule : pb_timer

// >>> bench/pb_bp_model.sv
// Purpose: Backplane-side model that raises protocol events toward the bank.
// Assumes: One request at a time; each event is a one-cycle pulse.
// Notes: Kinds 0-5 are faulty traffic, 6 an interlock read, 7 a proper masked write.
`timescale 1ns/1ps
module pb_bp_model (
  input wire logic mclk_i,
  input wire logic go_i,
  input wire logic [2:0] kind_i,
  output logic par_o,
  output logic wmask_o,
  output logic wdata_o,
  output logic rcmd_o,
  output logic rdata_o,
  output logic ilk_rd_o,
  output logic ilk_wr_o,
  output logic tx_o,
  output logic [3:0] id_drv_o,
  output logic [3:0] id_lat_o,
  output logic fault_o
);
  logic pend = 1'b0;
  logic [2:0] kq = 3'h0;
  logic [7:0] ev = 8'h00;
  logic wd = 1'b0;
  always @(posedge mclk_i) begin
    pend <= go_i;
    kq <= kind_i;
  end
  // Launch on the falling edge so the bank samples a settled pulse
  always @(negedge mclk_i) begin
    ev <= pend ? 8'h01 << kq : 8'h00;
    wd <= ev[7];
  end
  assign par_o = ev[0];
  assign wmask_o = ev[1] | ev[7]; // Kind 1 never follows with data
  assign wdata_o = wd;
  assign rcmd_o = ev[6];
  assign rdata_o = ev[2];
  assign ilk_rd_o = ev[6];
  assign ilk_wr_o = ev[3];
  assign tx_o = ev[4] | ev[5];
  assign id_drv_o = 4'h5;
  assign id_lat_o = ev[4] ? 4'hA : 4'h5; // A second unit drove the identifier
  assign fault_o = ev[5];
endmodule : pb_bp_model

// >>> bench/bus_adapter_csr_block_test.sv
// Purpose: Self-checking bench for the bridge configuration/control/status bank.
// Assumes: Shortened init and power-fail counts; pins settle within eight cycles.
// Notes: Register model kept in plain words and compared at every read.
`timescale 1ns/1ps
module bus_adapter_csr_block_test;
  import pb_pkg::*;
  localparam int AI = 20;
  localparam int PS = 10;
  localparam logic [5:0] TC = 6'h2A; // Arbitrary type code
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic reg_sel_i = 1'b0, reg_we_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h000;
  logic [31:0] reg_wdata_i = 32'h0000_0000, reg_rdata_o;
  logic bp_parity_err_i, bp_wmask_cmd_i, bp_wdata_i, bp_read_cmd_i, bp_rdata_i;
  logic bp_ilk_rmask_i, bp_ilk_wmask_periph_i, bp_transmitting_i, bp_fault_i;
  logic [3:0] bp_id_driven_i, bp_id_latched_i;
  logic backplane_a_i = 1'b0, bus_dead_i = 1'b0, ac_low_warning_i = 1'b0;
  logic periph_init_in_i = 1'b0, periph_ac_low_in_i = 1'b0, periph_power_ok_i = 1'b1;
  logic [1:0] jumper_i = 2'h0;
  logic interrupt_fielding_switch_i = 1'b1, periph_br_i = 1'b0, dma_read_sent_i = 1'b0;
  logic dma_read_data_i = 1'b0, dev_timeout_i = 1'b0, select_timeout_flag_i = 1'b0;
  logic slave_sync_timeout_flag_i = 1'b0;
  logic [5:0] dma_err_i = 6'h00;
  logic [8:0] dma_map_idx_i = 9'h000, failed_map_entry_reg_o;
  logic [3:0] vec_save_i = 4'h0, vec_read_ok_i = 4'h0, v;
  logic reg_ack_o, dma_map_blocked_o, dev_irq_o, dma_irq_o, pio_irq_o, env_irq_o;
  logic periph_ac_low_o, periph_dc_low_o, periph_init_o, init_busy_o, init_start_o;
  logic [4:0] map_disable_field_o;
  logic go = 1'b0;
  logic [2:0] kind = 3'h0;
  logic [31:0] seed = 32'h0000_4752, m_cfg, m_ctl, m_sts, d;
  int num_errors = 0, samples_checked = 0, cycles = 0, n;
  int good[4] = '{7, 6, 2, 3};

  pb_csr_bank #(.BRIDGE_INIT_CTL_CYC(AI), .PF_STEP_CYC(PS), .TYPE_CODE(TC)) i_dut (.*);
  pb_bp_model i_bp (
    .mclk_i(mclk_i),
    .go_i(go),
    .kind_i(kind),
    .par_o(bp_parity_err_i),
    .wmask_o(bp_wmask_cmd_i),
    .wdata_o(bp_wdata_i),
    .rcmd_o(bp_read_cmd_i),
    .rdata_o(bp_rdata_i),
    .ilk_rd_o(bp_ilk_rmask_i),
    .ilk_wr_o(bp_ilk_wmask_periph_i),
    .tx_o(bp_transmitting_i),
    .id_drv_o(bp_id_driven_i),
    .id_lat_o(bp_id_latched_i),
    .fault_o(bp_fault_i)
  );

  always #25 mclk_i = ~mclk_i;
  // Peripheral bus lines echo what the bank drives, half a cycle late
  always @(negedge mclk_i) begin
    periph_init_in_i <= periph_init_o;
    periph_ac_low_in_i <= periph_ac_low_o;
  end
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic test_done;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] seen, input logic [31:0] e);
    samples_checked++;
    if (seen !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, e);
    end
  endtask : check
  task automatic cyc(input int c);
    repeat (c) @(negedge mclk_i);
  endtask : cyc
  task automatic acc(input logic we, input logic [11:0] a, input logic [31:0] w,
                     input logic [31:0] e);
    @(negedge mclk_i);
    reg_sel_i = 1'b1;
    reg_we_i = we;
    reg_addr_i = a;
    reg_wdata_i = w;
    @(negedge mclk_i);
    reg_sel_i = 1'b0;
    check(32'(reg_ack_o), 32'h0000_0001);
    if (!we) check(reg_rdata_o, e);
  endtask : acc
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0000_0000, e);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] w);
    acc(1'b1, a, w, 32'h0000_0000);
  endtask : wr
  task automatic send(input int k);
    kind = 3'(k);
    go = 1'b1;
    @(negedge mclk_i);
    go = 1'b0;
    cyc(3);
  endtask : send

  initial begin
    jumper_i = 2'(rnd());
    cyc(16);
    rst_i = 1'b0;
    cyc(8);
    m_cfg = {24'h00_0000, TC, jumper_i};
    rd(CTL_OFS, CTL_RESET);
    rd(CFG_OFS, m_cfg);
    for (int k = 0; k < 6; k++) begin
      send(k);
      d = 32'h8000_0000 >> k;
      rd(CFG_OFS, m_cfg | d);
      wr(CFG_OFS, 32'h0000_0000);
      rd(CFG_OFS, m_cfg | d);
      wr(CFG_OFS, d);
    end
    foreach (good[i]) send(good[i]);
    rd(CFG_OFS, m_cfg);
    ac_low_warning_i = 1'b1;
    cyc(8);
    rd(CFG_OFS, m_cfg | 32'h0080_0000);
    check(32'(env_irq_o), 32'h0000_0001);
    ac_low_warning_i = 1'b0;
    cyc(8);
    rd(CFG_OFS, m_cfg | 32'h0040_0000);
    wr(CFG_OFS, 32'h00C0_0000);
    rd(CFG_OFS, m_cfg);
    periph_br_i = 1'b1;
    repeat (4) begin
      d = rnd() & 32'hFFFF_FFFC;
      m_ctl = d & 32'h7C00_003C;
      wr(CTL_OFS, d);
      dma_map_idx_i = 9'(rnd());
      interrupt_fielding_switch_i = d[31];
      cyc(2);
      rd(CTL_OFS, m_ctl);
      check(32'(map_disable_field_o), 32'(m_ctl[30:26]));
      check(32'(dma_map_blocked_o), 32'(int'(dma_map_idx_i) < 16 * int'(m_ctl[30:26])));
      check(32'(dev_irq_o), 32'(m_ctl[5] & d[31]));
    end
    wr(CTL_OFS, 32'h7C00_003C);
    backplane_a_i = 1'b1;
    @(negedge mclk_i);
    backplane_a_i = 1'b0;
    cyc(2);
    rd(CTL_OFS, 32'h7C00_0000);
    wr(CTL_OFS, 32'h0000_003C);
    bus_dead_i = 1'b1;
    @(negedge mclk_i);
    bus_dead_i = 1'b0;
    cyc(2);
    rd(CTL_OFS, 32'h0000_0010);
    wr(CTL_OFS, 32'h0000_001A);
    cyc(3 * PS + 8);
    check(32'({periph_ac_low_o, periph_dc_low_o, periph_init_o}), 32'h0000_0007);
    rd(CFG_OFS, m_cfg | 32'h0006_0000);
    wr(CTL_OFS, 32'h0000_0018);
    cyc(4 * PS + 10);
    check(32'({periph_ac_low_o, periph_dc_low_o, periph_init_o}), 32'h0000_0000);
    m_cfg[CFG_PIC] = 1'b1;
    rd(CFG_OFS, m_cfg);
    for (int b = 0; b < 6; b++) begin
      dma_map_idx_i = 9'(rnd());
      dma_err_i = 6'(1 << b);
      @(negedge mclk_i);
      dma_err_i = 6'h00;
      cyc(2);
      d = (b == 5) ? 32'h0000_0200 : 32'h0000_0008 << b;
      rd(STS_OFS, d);
      check(32'(failed_map_entry_reg_o), 32'(dma_map_idx_i));
      check(32'(dma_irq_o), 32'h0000_0001);
      wr(STS_OFS, d);
    end
    // First pass: the device times out first, so no flag may follow
    for (int t = 0; t < 2; t++) begin
      dma_read_sent_i = 1'b1;
      @(negedge mclk_i);
      dma_read_sent_i = 1'b0;
      cyc(READ_DATA_TIMEOUT_CYC - 20);
      rd(STS_OFS, 32'h0000_0000);
      dev_timeout_i = (t == 0);
      @(negedge mclk_i);
      dev_timeout_i = 1'b0;
      cyc(30);
    end
    v = 4'(rnd()) | 4'h8;
    dma_err_i = 6'h20;
    dma_map_idx_i = dma_map_idx_i ^ 9'h1FF;
    select_timeout_flag_i = 1'b1;
    slave_sync_timeout_flag_i = 1'b1;
    vec_save_i = v;
    @(negedge mclk_i);
    dma_err_i = 6'h00;
    select_timeout_flag_i = 1'b0;
    slave_sync_timeout_flag_i = 1'b0;
    vec_save_i = 4'h0;
    cyc(2);
    rd(STS_OFS, {4'h0, v, 24'h00_0407});
    check(32'({dma_irq_o, pio_irq_o}), 32'h0000_0003);
    check(32'(failed_map_entry_reg_o), 32'(dma_map_idx_i ^ 9'h1FF));
    wr(STS_OFS, 32'hFFFF_FFFF);
    rd(STS_OFS, {4'h0, v, 24'h00_0000});
    vec_read_ok_i = 4'h5;
    @(negedge mclk_i);
    vec_read_ok_i = 4'h0;
    cyc(2);
    rd(STS_OFS, {4'h0, v & 4'hA, 24'h00_0000});
    periph_power_ok_i = 1'b0;
    wr(CTL_OFS, 32'h0000_0001);
    check(32'(init_start_o), 32'h0000_0001);
    rd(CTL_OFS, 32'h0000_0000);
    n = 2;
    while (init_busy_o === 1'b1 && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    check(32'(n >= AI && n <= AI + 2), 32'h0000_0001);
    cyc(PS);
    rd(CFG_OFS, (m_cfg & 32'hFFFE_FFFF) | 32'h0006_0000);
    check(32'({periph_ac_low_o, periph_dc_low_o, periph_init_o}), 32'h0000_0007);
    periph_power_ok_i = 1'b1;
    cyc(5 * PS);
    rd(CFG_OFS, m_cfg);
    rd(STS_OFS, 32'h0000_0000);
    rd(CTL_OFS, 32'h0000_0000);
    rd(12'h010, 32'h0000_0000);
    test_done();
  end
endmodule : bus_adapter_csr_block_test
